// ---- design/cacl_change_latch.sv ----
// Function
// - Bit 3 latches a fifo limit alarm change until the next read.
// - Bit 2 latches a receive lock lost change since the previous read.
// - Bit 1 latches a receive signal lost change since the previous read.
// - A flag read clears its channel's flags, except any enabled change in that same cycle, and returns their values before clearing.
// - Live fifo limit alarm level reads at bit 3 of alarm status.
// - Live receive lock lost level reads at bit 2 of alarm status.
// - Live receive signal lost level reads at bit 1 of alarm status.
// - Bit 0 latches drive monitor changes; live level at alarm status bit 0.
// - Fifo limit change fires on both declaring and clearing the alarm.
// - A change sets its flag only while its enable bit is one.
// - Three channels, flag registers at 0x02, 0x0A and 0x12.
module cacl_change_latch (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire cacl_pkg::cacl_alarm_s [cacl_pkg::NUM_CH-1:0] alarm_in,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [cacl_pkg::DATA_W-1:0] reg_wdata,
  output logic [cacl_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid
);

  cacl_pkg::cacl_top_s st_r;
  cacl_pkg::cacl_top_s st_nxt;
  logic [cacl_pkg::NUM_CH-1:0] hit_en;
  logic [cacl_pkg::NUM_CH-1:0] hit_st;
  logic [cacl_pkg::NUM_CH-1:0] hit_al;
  logic [cacl_pkg::NUM_CH-1:0] rd_st;
  logic [cacl_pkg::NUM_CH-1:0][cacl_pkg::FLAG_W-1:0] chan_flags;
  cacl_pkg::cacl_alarm_s [cacl_pkg::NUM_CH-1:0] chan_live;
  // Enabled changes seen this cycle, watched by the checks below
  logic [cacl_pkg::NUM_CH-1:0][cacl_pkg::FLAG_W-1:0] chg_en;

  // Per channel address decode and latch instance
  for (genvar g = 0; g < cacl_pkg::NUM_CH; g++) begin : g_ch
    assign hit_en[g] = (reg_addr == cacl_pkg::ENABLE_ADDR[g]);
    assign hit_st[g] = (reg_addr == cacl_pkg::STATUS_ADDR[g]);
    assign hit_al[g] = (reg_addr == cacl_pkg::ALARM_ADDR[g]);
    assign rd_st[g] = reg_rd && hit_st[g];
    assign chg_en[g] = (alarm_in[g] ^ chan_live[g]) & st_r.enable[g];

    cacl_chan_latch u_chan (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .alarm_in(alarm_in[g]),
      .enable(st_r.enable[g]),
      .clear_on_read(rd_st[g]),
      .flags(chan_flags[g]),
      .live(chan_live[g])
    );
  end

  // Enable writes and read data mux; unmapped reads return zero
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = reg_rd;
    st_nxt.rdata = cacl_pkg::UNMAPPED_DATA;
    for (int i = 0; i < cacl_pkg::NUM_CH; i++) begin
      if (reg_wr && hit_en[i]) begin
        st_nxt.enable[i] = reg_wdata[cacl_pkg::FLAG_W-1:0];
      end
      if (reg_rd && hit_en[i]) begin
        st_nxt.rdata = {cacl_pkg::UNUSED_BITS, st_r.enable[i]};
      end
      if (rd_st[i]) begin
        st_nxt.rdata = {cacl_pkg::UNUSED_BITS, chan_flags[i]};
      end
      if (reg_rd && hit_al[i]) begin
        st_nxt.rdata = {cacl_pkg::UNUSED_BITS, chan_live[i]};
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;

  // A flag read of channel 0 returns the flags held before the clear
  a_read_pre_clear: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && (reg_addr == 8'h02))
    |=> (reg_rdata == {4'h0, $past(chan_flags[0])}))
    else $error("channel 0 read lost flags");

  // Channel 2 flags sit at 0x12 and are cleared by that read
  a_ch2_address: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && (reg_addr == 8'h12) && (alarm_in[2] == chan_live[2]))
    |=> ((reg_rdata[3:0] == $past(chan_flags[2])) && (chan_flags[2] == 4'h0)))
    else $error("channel 2 flag register misdecoded");

  // Upper nibble of every answer is zero
  a_upper_zero: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_rvalid
    |-> (reg_rdata[7:4] == 4'h0))
    else $error("reserved bits not zero");

  // Alarm status of channel 1 shows the live levels
  a_alarm_live: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && (reg_addr == 8'h0B))
    |=> (reg_rdata[3:0] == $past(chan_live[1])))
    else $error("alarm status wrong");

  // A read of another channel leaves channel 0 flags alone
  a_other_keeps: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && (reg_addr == 8'h0A))
    |=> ((chan_flags[0] & $past(chan_flags[0])) == $past(chan_flags[0])))
    else $error("foreign read cleared flags");

  // An enable write lands in the enable register
  a_enable_write: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_wr && (reg_addr == 8'h01))
    |=> (st_r.enable[0] == $past(reg_wdata[3:0])))
    else $error("enable write lost");

  // Read answer strobes exactly one cycle after each read
  a_rvalid_timing: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst)
    |-> (reg_rvalid == $past(reg_rd)))
    else $error("read answer timing wrong");

  // Reads of address zero, which holds no register, answer zero
  a_unmapped_zero: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && (reg_addr == 8'h00))
    |=> (reg_rdata == 8'h00))
    else $error("unmapped read not zero");

  // Between answers the read data rests at zero
  a_idle_data_zero: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !reg_rvalid
    |-> (reg_rdata == 8'h00))
    else $error("read data not idle");

  // Reset leaves no answer, no enable and no flag behind
  a_reset_state: assert property (
    @(posedge ref_clk)
    sys_rst |=> ((reg_rvalid == 1'b0) && (reg_rdata == 8'h00)
    && (st_r.enable == '0) && (chan_flags == '0)))
    else $error("state not cleared by reset");

  // Reads of an address that no register decodes answer zero
  a_unmapped_any: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_rd && !(|{hit_en, hit_st, hit_al}))
    |=> (reg_rdata == 8'h00))
    else $error("undecoded read not zero");

  // Per channel checks of the three register kinds
  for (genvar g = 0; g < cacl_pkg::NUM_CH; g++) begin : g_chk
    // A flag read returns the flags held before the clear
    a_flag_read_data: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      rd_st[g]
      |=> (reg_rdata == {cacl_pkg::UNUSED_BITS, $past(chan_flags[g])}))
      else $error("flag read data wrong");

    // A flag read with no enabled change leaves every flag clear
    a_flag_read_clear: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (rd_st[g] && (chg_en[g] == 4'h0))
      |=> (chan_flags[g] == 4'h0))
      else $error("flag read did not clear");

    // An enabled change in the clearing cycle stays latched
    a_read_set_wins: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (rd_st[g] && (chg_en[g] != 4'h0))
      |=> ((chan_flags[g] & $past(chg_en[g])) == $past(chg_en[g])))
      else $error("change lost in clearing read");

    // Alarm status reads show the live levels in bits 3 to 0
    a_alarm_read_data: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_rd && hit_al[g])
      |=> (reg_rdata == {cacl_pkg::UNUSED_BITS, $past(chan_live[g])}))
      else $error("alarm status read wrong");

    // Enable reads return the enable bits
    a_enable_read_data: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_rd && hit_en[g])
      |=> (reg_rdata == {cacl_pkg::UNUSED_BITS, $past(st_r.enable[g])}))
      else $error("enable read wrong");

    // An enable write lands at the next edge
    a_enable_write_lands: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (reg_wr && hit_en[g])
      |=> (st_r.enable[g] == $past(reg_wdata[3:0])))
      else $error("enable write not taken");

    // Enables change only by a write to their own address
    a_enable_holds: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !(reg_wr && hit_en[g])
      |=> $stable(st_r.enable[g]))
      else $error("enable changed without write");

    // Without a flag read no set flag drops
    a_no_read_keeps: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !rd_st[g]
      |=> ((chan_flags[g] & $past(chan_flags[g])) == $past(chan_flags[g])))
      else $error("flag dropped without its read");
  end

endmodule

// ---- design/cacl_pkg.sv ----
package cacl_pkg;

  // Channel count and register geometry
  localparam int NUM_CH = 3;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 4;

  // Register addresses, one entry per channel, channel 0 in the low slot
  localparam logic [NUM_CH-1:0][7:0] ENABLE_ADDR = {8'h11, 8'h09, 8'h01};
  localparam logic [NUM_CH-1:0][7:0] STATUS_ADDR = {8'h12, 8'h0A, 8'h02};
  localparam logic [NUM_CH-1:0][7:0] ALARM_ADDR = {8'h13, 8'h0B, 8'h03};

  // Field positions inside the flag, enable and alarm status registers
  localparam int FIFO_LIMIT_BIT = 3;
  localparam int LOCK_LOST_BIT = 2;
  localparam int SIGNAL_LOST_BIT = 1;
  localparam int DRIVE_MON_BIT = 0;

  // Reset values and the constant upper nibble
  localparam logic [FLAG_W-1:0] FLAG_RESET = 4'h0;
  localparam logic [FLAG_W-1:0] ENABLE_RESET = 4'h0;
  localparam logic [DATA_W-FLAG_W-1:0] UNUSED_BITS = 4'h0;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 8'h00;

  // Live alarm levels of one channel, bit 3 down to bit 0
  typedef struct packed {
    logic fifo_limit_alarm;
    logic receive_lock_lost;
    logic receive_signal_lost;
    logic transmit_drive_monitor;
  } cacl_alarm_s;

  // State of one channel latch
  typedef struct packed {
    cacl_alarm_s prev;
    logic [FLAG_W-1:0] flags;
  } cacl_chan_s;

  // State of the register block
  typedef struct packed {
    logic [NUM_CH-1:0][FLAG_W-1:0] enable;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } cacl_top_s;

endpackage

// ---- design/cacl_chan_latch.sv ----
// One channel: edge detection of the four alarm levels and clear-on-read flags
module cacl_chan_latch (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire cacl_pkg::cacl_alarm_s alarm_in,
  input wire logic [cacl_pkg::FLAG_W-1:0] enable,
  input wire logic clear_on_read,
  output logic [cacl_pkg::FLAG_W-1:0] flags,
  output cacl_pkg::cacl_alarm_s live
);

  cacl_pkg::cacl_chan_s st_r;
  cacl_pkg::cacl_chan_s st_nxt;
  logic [cacl_pkg::FLAG_W-1:0] evt;

  // Any edge of an enabled level is an event; set wins over the read clear
  always_comb begin
    st_nxt = st_r;
    evt = (alarm_in ^ st_r.prev) & enable;
    st_nxt.prev = alarm_in;
    if (clear_on_read) begin
      st_nxt.flags = cacl_pkg::FLAG_RESET;
    end
    st_nxt.flags = st_nxt.flags | evt;
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;
  assign live = st_r.prev;

  // An enabled change is latched at the next edge, even during a clearing read
  a_change_sets_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (evt != 4'h0) |=> ((flags & $past(evt)) == $past(evt)))
    else $error("enabled change not latched");

  // A read with no event leaves all flags clear
  a_read_clears_all: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clear_on_read && (evt == 4'h0)) |=> (flags == 4'h0))
    else $error("flags not cleared by read");

  // Without a read a set flag stays set
  a_flag_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !clear_on_read |=> ((flags & $past(flags)) == $past(flags)))
    else $error("flag dropped without read");

  // A disabled or absent change never raises a flag
  a_masked_stays: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!clear_on_read && (((alarm_in ^ live) & enable) == 4'h0)) |=> $stable(flags))
    else $error("flag set without enabled change");

  // Live alarm view follows the input with one cycle of delay
  a_live_follows: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (live == $past(alarm_in)))
    else $error("live alarm view wrong");

endmodule

// ---- tb/cacl_change_latch_tb.sv ----
module cacl_change_latch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  cacl_pkg::cacl_alarm_s [cacl_pkg::NUM_CH-1:0] alarm_in = '0;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] fa [3] = '{8'h02, 8'h0A, 8'h12};
  logic [7:0] m;

  cacl_change_latch cacl_change_latch_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .alarm_in(alarm_in), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // Clock of 10 ns period
  always #5 ref_clk = ~ref_clk;

  // Compare one value and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One register write, strobe held for the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // One register read, answer checked just after the taking edge while it stands
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic tog = 1'b0);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    if (tog) alarm_in[0][2] <= ~alarm_in[0][2];
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid}, 8'h01, "read valid");
    chk(reg_rdata, e, "read data");
  endtask

  // Drive one alarm level and let the change settle
  task automatic alarm(input int c, input int b, input logic v);
    @(posedge ref_clk);
    alarm_in[c][b] <= v;
    repeat (2) @(posedge ref_clk);
  endtask

  // Print counts and verdict, then stop
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #200us;
    fail_count++;
    print_verdict();
  end

  // Test sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      rd(fa[c], 8'h00);
      rd(fa[c] + 8'h01, 8'h00);
      rd(fa[c] - 8'h01, 8'h00);
    end
    $display("test reset values done");
    alarm(0, 3, 1'b1);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h08);
    alarm(0, 3, 1'b0);
    $display("test disabled events done");
    for (int c = 0; c < 3; c++) begin
      wr(fa[c] - 8'h01, 8'hFF);
      rd(fa[c] - 8'h01, 8'h0F);
    end
    for (int c = 0; c < 3; c++) begin
      for (int b = 0; b < 4; b++) begin
        m = 8'h01 << b;
        alarm(c, b, 1'b1);
        rd(fa[c], m);
        rd(fa[c], 8'h00);
        rd(fa[c] + 8'h01, m);
        alarm(c, b, 1'b0);
        rd(fa[c], m);
        rd(fa[c] + 8'h01, 8'h00);
      end
    end
    $display("test per bit changes done");
    alarm(1, 0, 1'b1);
    alarm(1, 3, 1'b1);
    wr(8'h0A, 8'h00);
    rd(8'h0A, 8'h09);
    rd(8'h0A, 8'h00);
    rd(8'h0B, 8'h09);
    rd(8'h04, 8'h00);
    $display("test multi flag and writes done");
    rd(8'h02, 8'h00, 1'b1);
    rd(8'h02, 8'h04);
    $display("test set during clear done");
    print_verdict();
  end
endmodule
